// ==== bsd_top.sv ====
// Purpose: Boot-strap decoder: strap capture, clock options, boot source sequencing, APB registers
// Assumes: APB requests synchronous to pclk; media answers with one-cycle done pulse
// Notes:   Zero-wait APB slave; straps are never resampled after the first capture
// Notes on behaviour
// - Strap bits 15:14 give the reference frequency: 00 19.2, 01 24, 10 25, 11 26 MHz.
// - Strap bits 11:6 have no effect on the boot behaviour.
// - Strap bit 5 disables the auxiliary clock output at 0 and enables it at 1.
// - Order code 11100 tries embedded card, removable card, serial zero, then USB zero.
// - Order code 11000 tries SPI zero, removable card, USB zero, then serial zero.
// - A source with no bootable image makes the sequencer move on to the next one.
// - The straps are sampled once after each reset release and the order comes from that sample.
`timescale 1ns/1ns
`default_nettype none
`include "bsd_defines.svh"

module bsd_top (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`BSD_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output var  logic [31:0]              prdata,
    output var  logic                     pready,
    output var  logic                     pslverr,
    input  wire logic [`BSD_STRAP_W-1:0]  boot_strap_pins,
    input  wire logic                     media_done,
    input  wire logic                     media_ok,
    output var  logic [1:0]               ref_freq_code,
    output var  logic                     aux_clock_output_en,
    output var  logic [2:0]               boot_src_sel,
    output var  logic                     boot_try,
    output var  logic                     boot_done,
    output var  logic                     boot_fail
);

    // ==========================================================
    // Strap capture and decode
    logic [`BSD_STRAP_W-1:0] strap_q;
    logic                    strap_valid;
    bsd_pkg::bsd_dec_s       dec;
    bsd_pkg::bsd_media_s     media;

    bsd_strap_latch u_latch (
        .pclk            (pclk),
        .presetn         (presetn),
        .boot_strap_pins (boot_strap_pins),
        .strap_q         (strap_q),
        .strap_valid     (strap_valid),
        .dec             (dec)
    );

    assign media.done = media_done;
    assign media.ok   = media_ok;

    // ==========================================================
    // Register state
    logic [15:0] tmo_r;
    logic [15:0] tmo_nxt;
    logic        restart_r;
    logic        restart_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    // ==========================================================
    // Sequencer state
    bsd_pkg::bsd_state_e state_r;
    bsd_pkg::bsd_state_e state_nxt;
    logic [1:0]          idx_r;
    logic [1:0]          idx_nxt;
    logic [2:0]          sel_r;
    logic [2:0]          sel_nxt;
    logic                try_r;
    logic                try_nxt;
    logic [2:0]          win_r;
    logic [2:0]          win_nxt;
    logic [1:0]          freq_r;
    logic [1:0]          freq_nxt;
    logic                aux_r;
    logic                aux_nxt;
    logic                tmr_load;
    logic                tmr_exp;
    logic                done_r;
    logic                fail_r;

    bsd_try_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (tmr_load),
        .run     (state_r == bsd_pkg::ST_TRY),
        .limit   (tmo_r),
        .expired (tmr_exp)
    );

    // ==========================================================
    // Source at a given place of the selected order
    function automatic logic [2:0] src_at(input logic [4:0] order, input logic [1:0] idx);
        bsd_pkg::bsd_src_e s;
        s = bsd_pkg::SRC_EMB_CARD;
        if (order == `BSD_ORDER_BUTTON) begin
            case (idx)
                2'h0:    s = bsd_pkg::SRC_SPI_PORT_ZERO;
                2'h1:    s = bsd_pkg::SRC_REM_CARD;
                2'h2:    s = bsd_pkg::SRC_USB_PORT_ZERO;
                default: s = bsd_pkg::SRC_SERIAL0;
            endcase
        end else begin
            case (idx)
                2'h0:    s = bsd_pkg::SRC_EMB_CARD;
                2'h1:    s = bsd_pkg::SRC_REM_CARD;
                2'h2:    s = bsd_pkg::SRC_SERIAL0;
                default: s = bsd_pkg::SRC_USB_PORT_ZERO;
            endcase
        end
        return s;
    endfunction : src_at

    // ==========================================================
    // APB decode, zero wait states
    // Answer prepared in the setup cycle so pready comes from a flop
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] status_word;

    assign setup  = psel && !penable;
    assign access = psel && penable && pready_r;
    assign mapped = (paddr == `BSD_OFF_STRAP) || (paddr == `BSD_OFF_STATUS) ||
                    (paddr == `BSD_OFF_CTRL) || (paddr == `BSD_OFF_RESULT);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`BSD_ST_FREQ_LO +: 2]  = freq_r;
        status_word[`BSD_ST_AUX_BIT]       = aux_r;
        status_word[`BSD_ST_RSV_BIT]       = dec.rsv_bad;
        status_word[`BSD_ST_OVALID_BIT]    = dec.order_ok;
        status_word[`BSD_ST_DONE_BIT]      = state_r == bsd_pkg::ST_DONE;
        status_word[`BSD_ST_FAIL_BIT]      = state_r == bsd_pkg::ST_FAIL;
        status_word[`BSD_ST_IDX_LO +: 2]   = idx_r;
        status_word[`BSD_ST_STATE_LO +: 3] = state_r;
        status_word[`BSD_ST_SRC_LO +: 3]   = sel_r;
    end

    always_comb begin
        pready_nxt  = setup;
        pslverr_nxt = setup && !mapped;
        prdata_nxt  = prdata_r;
        tmo_nxt     = tmo_r;
        restart_nxt = 1'b0;
        if (setup) begin
            case (paddr)
                `BSD_OFF_STRAP:  prdata_nxt = {16'h0000, strap_q};
                `BSD_OFF_STATUS: prdata_nxt = status_word;
                `BSD_OFF_CTRL:   prdata_nxt = {tmo_r, 16'h0000};
                `BSD_OFF_RESULT: prdata_nxt = {29'h0000_0000, win_r};
                default:         prdata_nxt = 32'h0000_0000;
            endcase
        end
        // Write takes effect only at the completing edge
        if (access && pwrite && (paddr == `BSD_OFF_CTRL)) begin
            tmo_nxt     = pwdata[`BSD_CTRL_TMO_HI:`BSD_CTRL_TMO_LO];
            restart_nxt = pwdata[`BSD_CTRL_RESTART_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            tmo_r     <= `BSD_TMO_RESET;
            restart_r <= 1'b0;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            tmo_r     <= tmo_nxt;
            restart_r <= restart_nxt;
        end
    end

    // ==========================================================
    // Boot sequencer
    // A restart walks the order again from the same captured straps
    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        sel_nxt   = sel_r;
        try_nxt   = try_r;
        win_nxt   = win_r;
        freq_nxt  = freq_r;
        aux_nxt   = aux_r;
        tmr_load  = 1'b0;
        case (state_r)
            bsd_pkg::ST_CAPTURE: begin
                if (strap_valid) begin
                    freq_nxt = dec.freq;
                    aux_nxt  = dec.aux_en;
                    idx_nxt  = 2'h0;
                    // Only the two documented codes carry an order
                    state_nxt = dec.order_ok ? bsd_pkg::ST_LAUNCH : bsd_pkg::ST_FAIL;
                end
            end
            bsd_pkg::ST_LAUNCH: begin
                sel_nxt   = src_at(dec.order, idx_r);
                try_nxt   = 1'b1;
                tmr_load  = 1'b1;
                state_nxt = bsd_pkg::ST_TRY;
            end
            bsd_pkg::ST_TRY: begin
                if (media.done && media.ok) begin
                    try_nxt   = 1'b0;
                    win_nxt   = sel_r;
                    state_nxt = bsd_pkg::ST_DONE;
                end else if (media.done || tmr_exp) begin
                    // No image or no answer: fall to the next source
                    try_nxt = 1'b0;
                    if (idx_r == `BSD_LAST_IDX) begin
                        state_nxt = bsd_pkg::ST_FAIL;
                    end else begin
                        idx_nxt   = idx_r + 2'h1;
                        state_nxt = bsd_pkg::ST_LAUNCH;
                    end
                end
            end
            bsd_pkg::ST_DONE, bsd_pkg::ST_FAIL: begin
                if (restart_r) begin
                    idx_nxt   = 2'h0;
                    state_nxt = dec.order_ok ? bsd_pkg::ST_LAUNCH : bsd_pkg::ST_FAIL;
                end
            end
            default: begin
                try_nxt   = 1'b0;
                state_nxt = bsd_pkg::ST_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= bsd_pkg::ST_CAPTURE;
            idx_r   <= 2'h0;
            sel_r   <= 3'h0;
            try_r   <= 1'b0;
            win_r   <= 3'h0;
            freq_r  <= 2'h0;
            aux_r   <= 1'b0;
            done_r  <= 1'b0;
            fail_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r   <= idx_nxt;
            sel_r   <= sel_nxt;
            try_r   <= try_nxt;
            win_r   <= win_nxt;
            freq_r  <= freq_nxt;
            aux_r   <= aux_nxt;
            // Taken from the next state so the flags rise together with it
            done_r  <= state_nxt == bsd_pkg::ST_DONE;
            fail_r  <= state_nxt == bsd_pkg::ST_FAIL;
        end
    end

    // ==========================================================
    // Outputs, each straight from a flop
    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign ref_freq_code       = freq_r;
    assign aux_clock_output_en = aux_r;
    assign boot_src_sel        = sel_r;
    assign boot_try            = try_r;
    assign boot_done           = done_r;
    assign boot_fail           = fail_r;

endmodule : bsd_top
`default_nettype wire

// ==== bsd_defines.svh ====
// Purpose: Offsets, field positions, reset values and counts of the boot-strap decoder
// Assumes: Included by bare name from the decoder design files
// Notes:   Definitions only
`ifndef BSD_DEFINES_SVH
`define BSD_DEFINES_SVH

// ==========================================================
// APB register map (byte addresses)
`define BSD_ADDR_W          12
`define BSD_OFF_STRAP       12'h000
`define BSD_OFF_STATUS      12'h004
`define BSD_OFF_CTRL        12'h008
`define BSD_OFF_RESULT      12'h00C

// ==========================================================
// Strap pin fields
`define BSD_STRAP_W         16
`define BSD_FREQ_HI         15
`define BSD_FREQ_LO         14
`define BSD_RSV_HI          13
`define BSD_RSV_LO          12
`define BSD_AUX_BIT         5
`define BSD_ORDER_HI        4
`define BSD_ORDER_LO        0
`define BSD_ORDER_DEFAULT   5'h1C
`define BSD_ORDER_BUTTON    5'h18
`define BSD_RSV_OK          2'h0

// ==========================================================
// Frequency codes
`define BSD_FREQ_19M2       2'h0
`define BSD_FREQ_24M        2'h1
`define BSD_FREQ_25M        2'h2
`define BSD_FREQ_26M        2'h3

// ==========================================================
// Status register fields
`define BSD_ST_FREQ_LO      0
`define BSD_ST_AUX_BIT      2
`define BSD_ST_RSV_BIT      3
`define BSD_ST_OVALID_BIT   4
`define BSD_ST_DONE_BIT     5
`define BSD_ST_FAIL_BIT     6
`define BSD_ST_IDX_LO       8
`define BSD_ST_STATE_LO     12
`define BSD_ST_SRC_LO       16

// ==========================================================
// Control register fields and reset values
`define BSD_CTRL_RESTART_BIT 0
`define BSD_CTRL_TMO_LO     16
`define BSD_CTRL_TMO_HI     31
`define BSD_TMO_RESET       16'h0400
`define BSD_LAST_IDX        2'h3

`endif

// ==== bsd_pkg.sv ====
// Purpose: Types shared by the boot-strap decoder files
// Assumes: Used with package scope, never imported
// Notes:   Offsets and counts live in bsd_defines.svh
package bsd_pkg;

    // ==========================================================
    // Boot sources
    typedef enum logic [2:0] {
        SRC_EMB_CARD = 3'b000,
        SRC_REM_CARD = 3'b001,
        SRC_SERIAL0  = 3'b010,
        SRC_USB_PORT_ZERO     = 3'b011,
        SRC_SPI_PORT_ZERO     = 3'b100
    } bsd_src_e;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_CAPTURE = 3'b000,
        ST_LAUNCH  = 3'b001,
        ST_TRY     = 3'b010,
        ST_DONE    = 3'b011,
        ST_FAIL    = 3'b100
    } bsd_state_e;

    // ==========================================================
    // Decoded strap word
    typedef struct packed {
        logic [1:0] freq;
        logic       rsv_bad;
        logic       aux_en;
        logic [4:0] order;
        logic       order_ok;
    } bsd_dec_s;

    // ==========================================================
    // Answer from the boot media
    typedef struct packed {
        logic done;
        logic ok;
    } bsd_media_s;

endpackage : bsd_pkg

// ==== bsd_strap_latch.sv ====
// Purpose: Captures the strap pins once after reset release and decodes them
// Assumes: Strap pins stable at the first edge after presetn rises
// Notes:   The capture never repeats until the next reset
`timescale 1ns/1ns
`default_nettype none
`include "bsd_defines.svh"

module bsd_strap_latch (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [`BSD_STRAP_W-1:0]  boot_strap_pins,
    output var  logic [`BSD_STRAP_W-1:0]  strap_q,
    output var  logic                     strap_valid,
    output var  bsd_pkg::bsd_dec_s        dec
);

    logic [`BSD_STRAP_W-1:0] strap_r;
    logic [`BSD_STRAP_W-1:0] strap_nxt;
    logic                    valid_r;
    logic                    valid_nxt;

    // ==========================================================
    // Capture
    // Pins taken by a clocked process, never by the async reset
    always_comb begin
        strap_nxt = strap_r;
        valid_nxt = valid_r;
        if (!valid_r) begin
            strap_nxt = boot_strap_pins;
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_r <= 16'h0000;
            valid_r <= 1'b0;
        end else begin
            strap_r <= strap_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ==========================================================
    // Decode; bits 11:6 take no part in it
    always_comb begin
        dec.freq     = strap_r[`BSD_FREQ_HI:`BSD_FREQ_LO];
        dec.rsv_bad  = strap_r[`BSD_RSV_HI:`BSD_RSV_LO] != `BSD_RSV_OK;
        dec.aux_en   = strap_r[`BSD_AUX_BIT];
        dec.order    = strap_r[`BSD_ORDER_HI:`BSD_ORDER_LO];
        dec.order_ok = (dec.order == `BSD_ORDER_DEFAULT) || (dec.order == `BSD_ORDER_BUTTON);
    end

    assign strap_q     = strap_r;
    assign strap_valid = valid_r;

endmodule : bsd_strap_latch
`default_nettype wire

// ==== bsd_try_timer.sv ====
// Purpose: Per-attempt watchdog of the boot sequencer
// Assumes: load and run never high together
// Notes:   A limit of zero raises expired in the second running cycle
`timescale 1ns/1ns
`default_nettype none

module bsd_try_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic        run,
    input  wire logic [15:0] limit,
    output var  logic        expired
);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        exp_r;
    logic        exp_nxt;

    // ==========================================================
    // Down counter; expiry is a one-cycle pulse
    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (load) begin
            cnt_nxt = limit;
        end else if (run && !exp_r) begin
            if (cnt_r == 16'h0000) begin
                exp_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;

endmodule : bsd_try_timer
`default_nettype wire

// ==== bsd_checker_properties.sv ====
// Purpose: Port-level properties of the boot-strap decoder
// Assumes: Bound to bsd_top; straps stable at the first edge after release
// Notes:   Helper logic mirrors the one-shot strap sample
`timescale 1ns/1ns
`default_nettype none
`include "bsd_defines.svh"

module bsd_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] boot_strap_pins,
    input wire logic        media_done,
    input wire logic        media_ok,
    input wire logic [1:0]  ref_freq_code,
    input wire logic        aux_clock_output_en,
    input wire logic [2:0]  boot_src_sel,
    input wire logic        boot_try,
    input wire logic        boot_done,
    input wire logic        boot_fail
);
    logic [2:0]  cnt_r, cnt_nxt;
    logic [15:0] cap_r, cap_nxt;
    logic        ord_ok;

    // ==========================================================
    // Edges since release, and our own copy of the first sample
    always_comb begin
        cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
        cap_nxt = (cnt_r == 3'h0) ? boot_strap_pins : cap_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 3'h0;
            cap_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
            cap_r <= cap_nxt;
        end
    end
    assign ord_ok = (cap_r[4:0] == 5'h1C) || (cap_r[4:0] == 5'h18);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Properties
    property p_freq; cnt_r >= 3'h2 |-> ref_freq_code == cap_r[15:14]; endproperty
    a_freq: assert property (p_freq) else $error("freq code wrong");
    property p_aux; cnt_r >= 3'h2 |-> aux_clock_output_en == cap_r[5]; endproperty
    a_aux: assert property (p_aux) else $error("aux enable wrong");
    property p_first_emb; cnt_r == 3'h3 && cap_r[4:0] == 5'h1C |-> boot_try && boot_src_sel == 3'h0; endproperty
    a_first_emb: assert property (p_first_emb) else $error("default start wrong");
    property p_first_spi; cnt_r == 3'h3 && cap_r[4:0] == 5'h18 |-> boot_try && boot_src_sel == 3'h4; endproperty
    a_first_spi: assert property (p_first_spi) else $error("button start wrong");
    property p_bad_order; cnt_r == 3'h3 && !ord_ok |-> ##[0:1] (boot_fail && !boot_try); endproperty
    a_bad_order: assert property (p_bad_order) else $error("bad order not failed");
    property p_move_on; boot_try && media_done && !media_ok |=> !boot_try ##1 (boot_try || boot_fail); endproperty
    a_move_on: assert property (p_move_on) else $error("no move to next source");
    property p_success; boot_try && media_done && media_ok |=> !boot_try ##[0:1] boot_done; endproperty
    a_success: assert property (p_success) else $error("success not done");
    property p_sel_hold; boot_try && $past(boot_try) |-> $stable(boot_src_sel); endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("source moved");
    property p_apb_wait; psel && !penable |=> pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
    property p_apb_err; pready |-> pslverr == (paddr > `BSD_OFF_RESULT); endproperty
    a_apb_err: assert property (p_apb_err) else $error("apb error flag wrong");

    c_done: cover property (boot_done);
    c_fail: cover property (boot_fail);
    c_spi: cover property ($rose(boot_try) && boot_src_sel == 3'h4);
    c_err: cover property (pslverr);
endmodule : bsd_checker

bind bsd_top bsd_checker u_bsd_checker (.*);
`default_nettype wire

// ==== bsd_media_model.sv ====
// Purpose: Boot media on the far side of the decoder
// Assumes: One answer per attempt unless the source is silent; masks set by the bench
// Notes:   Answer delay grows with source number, so prompt and slow media both occur
`timescale 1ns/1ns
`default_nettype none

module bsd_media_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       boot_try,
    input  wire logic [2:0] boot_src_sel,
    input  wire logic [4:0] ok_mask,
    input  wire logic [4:0] silent_mask,
    output var  logic       media_done,
    output var  logic       media_ok
);
    logic [3:0] wait_r;
    logic       sent_r;

    // ==========================================================
    // At most one done pulse per attempt, none from a silent source; ok wanders when not qualified
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            media_done <= 1'b0;
            media_ok   <= 1'b0;
            wait_r     <= 4'h0;
            sent_r     <= 1'b0;
        end else begin
            media_done <= 1'b0;
            media_ok   <= ~media_ok;
            if (!boot_try) begin
                sent_r <= 1'b0;
                wait_r <= 4'h0;
            end else if (!sent_r && !silent_mask[boot_src_sel]) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r == {1'b0, boot_src_sel}) begin
                    media_done <= 1'b1;
                    media_ok   <= ok_mask[boot_src_sel];
                    sent_r     <= 1'b1;
                end
            end
        end
    end
endmodule : bsd_media_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench of the boot-strap decoder
// Assumes: Straps set while reset is low
// Notes:   Source order is logged at every rise of boot_try
`timescale 1ns/1ns
`default_nettype none
`include "bsd_defines.svh"

module tb_top;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, media_done, media_ok, aux_en;
    logic        boot_try, boot_done, boot_fail, err, try_d;
    logic [15:0] strap;
    logic [1:0]  freq;
    logic [2:0]  src_sel;
    logic [4:0]  ok_m, sil_m;
    logic [2:0]  seq_q[$];
    int          error_cnt, num_checks;

    bsd_top u_bsd_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .boot_strap_pins(strap), .media_done, .media_ok, .ref_freq_code(freq), .aux_clock_output_en(aux_en),
        .boot_src_sel(src_sel), .boot_try, .boot_done, .boot_fail
    );
    bsd_media_model u_bsd_media_model (
        .pclk, .presetn, .boot_try, .boot_src_sel(src_sel), .ok_mask(ok_m), .silent_mask(sil_m),
        .media_done, .media_ok
    );

    // ==========================================================
    // Clock, and the log of launched sources
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (presetn === 1'b1 && boot_try === 1'b1 && try_d !== 1'b1) seq_q.push_back(src_sel);
        try_d <= boot_try;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        chk("pready", 32'h1, pready);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_end;
        int k;
        for (k = 0; k < 3000; k++) begin
            @(posedge pclk);
            if (boot_done === 1'b1 || boot_fail === 1'b1) break;
        end
        chk("ended", 32'h1, boot_done | boot_fail);
    endtask : wait_end

    task automatic check_run(input logic [11:0] es, input int n, input logic dn);
        chk("tries", n, seq_q.size());
        for (int i = 0; i < n && i < seq_q.size(); i++) chk("source", es[11-3*i -: 3], seq_q[i]);
        chk("done", dn, boot_done);
        chk("fail", !dn, boot_fail);
    endtask : check_run

    task automatic boot_run(input logic [15:0] p, input logic [4:0] ok, input logic [11:0] es,
                            input int n, input logic dn);
        presetn <= 1'b0;
        strap   <= p;
        ok_m    <= ok;
        sil_m   <= 5'h00;
        repeat (4) @(posedge pclk);
        seq_q.delete();
        presetn <= 1'b1;
        wait_end();
        check_run(es, n, dn);
        chk("freq", p[15:14], freq);
        chk("aux", p[5], aux_en);
    endtask : boot_run

    task automatic restart(input logic [31:0] c);
        seq_q.delete();
        apb(1'b1, `BSD_OFF_CTRL, c);
        for (int k = 0; k < 200 && seq_q.size() == 0; k++) @(posedge pclk);
        wait_end();
    endtask : restart

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // ==========================================================
    // Scenarios
    task automatic t_default;
        boot_run(16'h001C, 5'h00, 12'h053, 4, 1'b0);
        $display("test default done");
    endtask : t_default

    task automatic t_button;
        boot_run(16'hCFF8, 5'h08, 12'h858, 3, 1'b1);
        apb(1'b0, `BSD_OFF_RESULT, 32'h0);
        chk("result", 32'h3, rd);
        strap <= 16'h001C;
        apb(1'b0, `BSD_OFF_STRAP, 32'h0);
        chk("strap", 32'hCFF8, rd);
        restart(32'h0400_0001);
        check_run(12'h858, 3, 1'b1);
        chk("freq", 32'h3, freq);
        $display("test button done");
    endtask : t_button

    task automatic t_freq;
        boot_run(16'h401C, 5'h01, 12'h000, 1, 1'b1);
        boot_run(16'h801C, 5'h01, 12'h000, 1, 1'b1);
        $display("test freq done");
    endtask : t_freq

    task automatic t_reserved;
        boot_run(16'h101C, 5'h02, 12'h040, 2, 1'b1);
        apb(1'b0, `BSD_OFF_STATUS, 32'h0);
        chk("reserved", 32'h1, rd[3]);
        $display("test reserved bits done");
    endtask : t_reserved

    task automatic t_timeout;
        sil_m <= 5'h01;
        restart(32'h0004_0001);
        check_run(12'h040, 2, 1'b1);
        apb(1'b0, `BSD_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0004_0000, rd);
        $display("test silent source done");
    endtask : t_timeout

    task automatic t_apb;
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, `BSD_OFF_STRAP, 32'h0000_0000);
        chk("ro err", 32'h0, err);
        apb(1'b0, `BSD_OFF_STRAP, 32'h0);
        chk("strap ro", 32'h101C, rd);
        boot_run(16'h0000, 5'h00, 12'h000, 0, 1'b0);
        $display("test bus done");
    endtask : t_apb

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        strap = 16'h001C;
        ok_m = 5'h00;
        sil_m = 5'h00;
        try_d = 1'b0;
        t_default();
        t_button();
        t_freq();
        t_reserved();
        t_timeout();
        t_apb();
        end_sim();
    end
    initial begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
